// file: design/fmr_pkg.sv
// Operation
// - Probe ramp over 500 ms with check on: report, float FETs, retry.
// - Probe pulse before decay with check on: report, float FETs, retry.
// - Probe ramp timeout during R/L measurement: report, float, latch.
// - Low back-EMF during Ke measurement: report, float FETs, latch.
// - Missed watchdog tickle: mode 0 reports only, mode 1 floats, latches.
// - Every memory read is checked; an error sets the memory fault.
// - Memory fault mode 0 floats and latches; mode 1 only reports.
// - Checksum error reported; mode 0 floats and latches, 1 reports only.
// - Enabled current-loop saturation reported, FETs drive, clears itself.
// - Enabled speed-loop saturation reported, FETs drive, clears itself.
// - Main supply undervoltage disables FETs, pump, logic; reset state.
// - Analog rail undervoltage disables FETs, pump, logic; reset state.
// - Buck feedback undervoltage is flagged; regulation keeps going.
// - Pump undervoltage floats FETs, drives pin low, sets status bits.
// - Driving and pin resume by themselves once pump undervoltage ends.
// - Pump undervoltage status bit stays until the host fault clear.
// - Retry faults resume and clear their status after retry time.
// - Latched faults end only when gone and a fault clear is issued.
`default_nettype none
package fmr_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int PROBE_TIMEOUT_MS = 500;
   localparam int MS_CYC = 1000000 / CLK_PERIOD_NS;
   localparam int PROBE_TIMEOUT_CYC = PROBE_TIMEOUT_MS * MS_CYC;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_FAULT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [31:0] CFG_RST = 32'h0064_0A00;
   localparam logic [31:0] CFG_WMASK = 32'hFFFF_FF7F;
   localparam int CMD_CLEAR = 0;
   localparam int CMD_TICKLE = 1;
   // Fault flag positions.
   localparam int NF = 12;
   localparam int F_RAMPUP = 0;
   localparam int F_RAMPDN = 1;
   localparam int F_RATE = 2;
   localparam int F_MPULSE = 3;
   localparam int F_MBEMF = 4;
   localparam int F_WDT = 5;
   localparam int F_MEM = 6;
   localparam int F_CRC = 7;
   localparam int F_CSAT = 8;
   localparam int F_SSAT = 9;
   localparam int F_PUMP = 10;
   localparam int F_BUCK = 11;
   localparam logic [NF-1:0] RETRY_MASK = 12'h007;
   localparam logic [NF-1:0] LATCH_MASK = 12'h4F8;
   localparam logic [NF-1:0] LIVE_MASK = 12'hB00;
   localparam logic [NF-1:0] PIN_MASK = 12'h3FF;
   localparam logic [NF-1:0] IRQ_MASK_RST = 12'h000;

   typedef struct packed {
      logic [15:0] wdt_interval_ms;
      logic [7:0] lock_retry_time;
      logic rsvd;
      logic sat_en;
      logic crc_resp;
      logic memory_fault_response;
      logic host_watchdog_response;
      logic host_watchdog_en;
      logic probe_rate_check_en;
      logic probe_timeout_check_en;
   } fmr_cfg_t;

   typedef struct packed {
      logic probe_rampup;
      logic probe_rampdn;
      logic probe_pulse_start;
      logic probe_decayed;
      logic meas_rl;
      logic meas_ke;
      logic backemf_low;
      logic mem_rd_done;
      logic mem_ok;
      logic crc_err;
      logic cur_sat;
      logic spd_sat;
      logic main_uv;
      logic analog_uv;
      logic buck_uv;
      logic pump_uv;
   } fmr_cond_t;
endpackage
`default_nettype wire

// file: design/fmr_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Timing request
   input wire logic clr,
   input wire logic run,
   input wire logic [W-1:0] limit,
   // Expiry pulse
   output logic fire
);
   logic [W-1:0] cnt;
   logic [W:0] cnt_inc;

   if (W < 2) begin : g_chk
      $error("fmr_timer: W must be at least 2");
   end

   // A limit of zero behaves as one cycle so the timer always expires.
   assign cnt_inc = {1'b0, cnt} + {{W{1'b0}}, 1'b1};
   assign fire = run && !clr && (cnt_inc >= {1'b0, limit});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (ce) begin
         if (clr || !run || fire) begin
            cnt <= '0;
         end else begin
            cnt <= cnt_inc[W-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// file: design/fmr_irq.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_irq #(
   parameter int NF = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Events and software access
   input wire logic [NF-1:0] ev,
   input wire logic [NF-1:0] clr_mask,
   input wire logic mask_we,
   input wire logic [NF-1:0] mask_wdata,
   // State
   output logic [NF-1:0] status,
   output logic [NF-1:0] mask,
   output logic irq
);
   if (NF < 1) begin : g_chk
      $error("fmr_irq: NF must be at least 1");
   end

   // Only bits already returned by the read are cleared, so an event
   // landing between setup and access is kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         mask <= NF'(fmr_pkg::IRQ_MASK_RST);
      end else if (ce) begin
         status <= (status & ~clr_mask) | ev;
         if (mask_we) begin
            mask <= mask_wdata;
         end
      end
   end

   assign irq = |(status & mask);
endmodule
`default_nettype wire

// file: design/fmr_top.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module fmr_top #(
   parameter int AW = 12,
   parameter int PROBE_TIMEOUT_CYC = fmr_pkg::PROBE_TIMEOUT_CYC,
   parameter int MS_CYC = fmr_pkg::MS_CYC
) (
   // Clock, reset and enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Conditions from the motor controller and supervisors
   input wire fmr_pkg::fmr_cond_t cond,
   // Responses
   output logic fault_out_n,
   output logic fets_float,
   output logic pump_en,
   output logic logic_reset,
   output logic irq
);
   localparam int NF = fmr_pkg::NF;

   fmr_pkg::fmr_cfg_t cfg;
   logic [NF-1:0] flags;
   logic [NF-1:0] next_flags;
   logic [NF-1:0] set_v;
   logic [NF-1:0] clr_v;
   logic [NF-1:0] live_v;
   logic [NF-1:0] float_mask;
   logic [NF-1:0] irq_status;
   logic [NF-1:0] irq_mask;
   logic [NF-1:0] irq_clr;
   logic [1:0] ramp_run;
   logic [1:0] ramp_fire;
   logic [1:0] sat_live;
   logic [31:0] retry_limit;
   logic [31:0] wdt_limit;
   logic [31:0] rd_data;
   logic supply_uv;
   logic retry_fire;
   logic wdt_fire;
   logic probe_to;
   logic ctrl_fault;
   logic driver_fault;
   logic pin_any;

   if (AW < 5) begin : g_chk_aw
      $error("fmr_top: AW must be at least 5");
   end
   if (PROBE_TIMEOUT_CYC < 1 || MS_CYC < 1) begin : g_chk_cyc
      $error("fmr_top: cycle counts must be at least 1");
   end

   // Which flags float the power stage under the present configuration.
   function automatic logic [NF-1:0] floats(input fmr_pkg::fmr_cfg_t c);
      logic [NF-1:0] m;
      m = fmr_pkg::RETRY_MASK;
      m[fmr_pkg::F_MPULSE] = 1'b1;
      m[fmr_pkg::F_MBEMF] = 1'b1;
      m[fmr_pkg::F_WDT] = c.host_watchdog_response;
      m[fmr_pkg::F_MEM] = !c.memory_fault_response;
      m[fmr_pkg::F_CRC] = !c.crc_resp;
      return m;
   endfunction

   // ---------------- APB decode ----------------
   wire logic [7:0] addr_lo = paddr[7:0];
   wire logic addr_hi_zero = (paddr >> 8) == '0;
   wire logic sel_cfg = addr_hi_zero && addr_lo == fmr_pkg::ADDR_CFG;
   wire logic sel_cmd = addr_hi_zero && addr_lo == fmr_pkg::ADDR_CMD;
   wire logic sel_flt = addr_hi_zero && addr_lo == fmr_pkg::ADDR_FAULT;
   wire logic sel_ist = addr_hi_zero && addr_lo == fmr_pkg::ADDR_IRQ_STAT;
   wire logic sel_imk = addr_hi_zero && addr_lo == fmr_pkg::ADDR_IRQ_MASK;
   wire logic addr_ok = sel_cfg || sel_cmd || sel_flt || sel_ist || sel_imk;
   wire logic setup_rd = ce && psel && !penable && !pwrite;
   wire logic access = ce && psel && penable;
   wire logic wr_ok = access && pwrite && addr_ok;
   wire logic rd_ok = access && !pwrite && addr_ok;
   wire logic clear_cmd = wr_ok && sel_cmd && pwdata[fmr_pkg::CMD_CLEAR];
   wire logic tickle = wr_ok && sel_cmd && pwdata[fmr_pkg::CMD_TICKLE];

   // The slave never inserts wait states while enabled.
   assign pready = ce;
   assign pslverr = psel && penable && !addr_ok;

   assign ctrl_fault = |flags[fmr_pkg::F_SSAT:0];
   assign driver_fault = flags[fmr_pkg::F_PUMP] || cond.pump_uv;
   assign rd_data = sel_cfg ? 32'(cfg) :
                    sel_flt ? 32'({driver_fault, ctrl_fault, flags}) :
                    sel_ist ? 32'(irq_status) :
                    sel_imk ? 32'(irq_mask) : 32'h0000_0000;
   // Read-clear uses the word latched at setup, not the live status.
   assign irq_clr = (rd_ok && sel_ist) ? prdata[NF-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= rd_data;
      end
   end

   // Reset state of the core also returns configuration to its defaults.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= fmr_pkg::CFG_RST;
      end else if (ce) begin
         if (supply_uv) begin
            cfg <= fmr_pkg::CFG_RST;
         end else if (wr_ok && sel_cfg) begin
            cfg <= pwdata & fmr_pkg::CFG_WMASK;
         end
      end
   end

   // ---------------- Timers ----------------
   assign supply_uv = cond.main_uv || cond.analog_uv;
   assign ramp_run = {cond.probe_rampdn, cond.probe_rampup};

   for (genvar i = 0; i < 2; i++) begin : g_ramp
      fmr_timer #(.W(32)) u_ramp (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .clr(supply_uv),
         .run(ramp_run[i]),
         .limit(32'(PROBE_TIMEOUT_CYC)),
         .fire(ramp_fire[i])
      );
   end

   assign retry_limit = 32'(cfg.lock_retry_time) * 32'(MS_CYC);
   fmr_timer #(.W(32)) u_retry (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clr(supply_uv),
      .run(|(flags & fmr_pkg::RETRY_MASK)),
      .limit(retry_limit),
      .fire(retry_fire)
   );

   // A tickle restarts the interval; the host owns keeping it in time.
   assign wdt_limit = 32'(cfg.wdt_interval_ms) * 32'(MS_CYC);
   fmr_timer #(.W(32)) u_wdt (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clr(supply_uv || tickle),
      .run(cfg.host_watchdog_en),
      .limit(wdt_limit),
      .fire(wdt_fire)
   );

   // ---------------- Fault flags ----------------
   assign probe_to = |ramp_fire;
   assign sat_live = {cond.spd_sat, cond.cur_sat} & {2{cfg.sat_en}};

   always_comb begin
      set_v = '0;
      live_v = '0;
      set_v[fmr_pkg::F_RAMPUP] = ramp_fire[0] && !cond.meas_rl &&
                                 cfg.probe_timeout_check_en;
      set_v[fmr_pkg::F_RAMPDN] = ramp_fire[1] && !cond.meas_rl &&
                                 cfg.probe_timeout_check_en;
      set_v[fmr_pkg::F_RATE] = cfg.probe_rate_check_en &&
                               cond.probe_pulse_start &&
                               !cond.probe_decayed;
      set_v[fmr_pkg::F_MPULSE] = probe_to && cond.meas_rl;
      live_v[fmr_pkg::F_MBEMF] = cond.meas_ke && cond.backemf_low;
      set_v[fmr_pkg::F_MBEMF] = live_v[fmr_pkg::F_MBEMF];
      set_v[fmr_pkg::F_WDT] = cfg.host_watchdog_en && wdt_fire;
      set_v[fmr_pkg::F_MEM] = cond.mem_rd_done && !cond.mem_ok;
      set_v[fmr_pkg::F_CRC] = cond.crc_err;
      live_v[fmr_pkg::F_PUMP] = cond.pump_uv;
      set_v[fmr_pkg::F_PUMP] = cond.pump_uv;
   end

   // Retry bits drop on expiry; latched bits need a clear and a gone cause.
   assign clr_v = ({NF{retry_fire}} & fmr_pkg::RETRY_MASK) |
                  ({NF{clear_cmd}} & fmr_pkg::LATCH_MASK &
                   ~live_v);

   always_comb begin
      next_flags = ((flags & ~clr_v) | set_v) & ~fmr_pkg::LIVE_MASK;
      next_flags[fmr_pkg::F_CSAT] = sat_live[0];
      next_flags[fmr_pkg::F_SSAT] = sat_live[1];
      next_flags[fmr_pkg::F_BUCK] = cond.buck_uv;
      if (supply_uv) begin
         next_flags = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else if (ce) begin
         flags <= next_flags;
      end
   end

   // ---------------- Outputs ----------------
   assign float_mask = floats(cfg);
   assign pin_any = |(flags & fmr_pkg::PIN_MASK) || cond.pump_uv;

   // Buck undervoltage only reports; the regulator is never turned off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_out_n <= 1'b1;
         fets_float <= 1'b1;
         pump_en <= 1'b0;
         logic_reset <= 1'b1;
      end else if (ce) begin
         fault_out_n <= !pin_any || supply_uv;
         fets_float <= supply_uv || cond.pump_uv ||
                       |(flags & float_mask);
         pump_en <= !supply_uv;
         logic_reset <= supply_uv;
      end
   end

   fmr_irq #(.NF(NF)) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .ev(next_flags & ~flags),
      .clr_mask(irq_clr),
      .mask_we(wr_ok && sel_imk),
      .mask_wdata(pwdata[NF-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ---------------- Checks ----------------
   probe_retry_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && flags[fmr_pkg::F_RAMPUP]
      |=> fets_float && !fault_out_n)
      else $error("probe timeout did not float and report");

   rate_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && cfg.probe_rate_check_en &&
      cond.probe_pulse_start && !cond.probe_decayed
      |=> flags[fmr_pkg::F_RATE])
      else $error("probe rate fault not flagged");

   pulse_latch_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && flags[fmr_pkg::F_MPULSE] && !clear_cmd && !supply_uv
      |=> flags[fmr_pkg::F_MPULSE])
      else $error("measurement pulse fault dropped without clear");

   bemf_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && cond.meas_ke && cond.backemf_low
      |=> flags[fmr_pkg::F_MBEMF] ##1 (fets_float || !ce))
      else $error("back-EMF fault not latched with float");

   wdt_pin_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && flags[fmr_pkg::F_WDT] && !supply_uv |=> !fault_out_n)
      else $error("watchdog fault not on pin");

   mem_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && cond.mem_rd_done && !cond.mem_ok
      |=> flags[fmr_pkg::F_MEM])
      else $error("memory fault not flagged");

   sat_auto_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv |=> flags[fmr_pkg::F_CSAT] == $past(sat_live[0]))
      else $error("current saturation flag not live");

   supply_rst_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && supply_uv |=> logic_reset && fets_float && !pump_en &&
      flags == '0)
      else $error("supply undervoltage did not reset core");

   pump_uv_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && cond.pump_uv
      |=> !fault_out_n && fets_float && flags[fmr_pkg::F_PUMP])
      else $error("pump undervoltage response missing");

   pump_sticky_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && flags[fmr_pkg::F_PUMP] && !clear_cmd && !supply_uv
      |=> flags[fmr_pkg::F_PUMP])
      else $error("pump status cleared without command");

   retry_clr_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && retry_fire && !supply_uv && !(|set_v[2:0])
      |=> (flags & fmr_pkg::RETRY_MASK) == '0)
      else $error("retry faults not released after retry time");

   mem_float_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && flags[fmr_pkg::F_MEM] &&
      !cfg.memory_fault_response |=> fets_float)
      else $error("memory fault mode 0 did not float");

   crc_float_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv && flags[fmr_pkg::F_CRC] && !cfg.crc_resp
      |=> fets_float && !fault_out_n)
      else $error("checksum fault mode 0 did not float and report");

   speed_sat_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv |=> flags[fmr_pkg::F_SSAT] == $past(sat_live[1]))
      else $error("speed saturation flag not live");

   buck_live_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !supply_uv |=> flags[fmr_pkg::F_BUCK] == $past(cond.buck_uv))
      else $error("buck undervoltage flag not live");

   pump_release_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !cond.pump_uv && (flags & fmr_pkg::PIN_MASK) == '0
      |=> fault_out_n)
      else $error("fault pin held with no pending fault");

   pulse_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && clear_cmd && !(probe_to && cond.meas_rl)
      |=> !flags[fmr_pkg::F_MPULSE])
      else $error("measurement pulse fault not cleared by command");

   freeze_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ce |=> flags == $past(flags) && cfg == $past(cfg))
      else $error("state changed while clock enable low");
endmodule
`default_nettype wire

// file: verif/fmr_host.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_host (
   // Clock
   input wire logic pclk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // Called just after a rising edge; returns one edge after the release,
   // so a following call never re-drives psel in the same time step.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {4'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q,
         output logic e);
      xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask

   task automatic clear_faults();
      wr(fmr_pkg::ADDR_CMD, 32'h0000_0001);
   endtask

   task automatic tickle();
      wr(fmr_pkg::ADDR_CMD, 32'h0000_0002);
   endtask
endmodule
`default_nettype wire

// file: verif/motor_fault_response_manager_bench.sv
`timescale 1ns/100ps
`default_nettype none
module motor_fault_response_manager_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic fault_out_n, fets_float, pump_en, logic_reset, irq;
   logic ce = 1'b1;
   fmr_pkg::fmr_cond_t cond = '0;
   int num_errors = 0;
   int n_compared = 0;
   localparam logic [7:0] CFG = fmr_pkg::ADDR_CFG;
   localparam logic [7:0] FLT = fmr_pkg::ADDR_FAULT;

   always #10 pclk = ~pclk;

   fmr_top #(.PROBE_TIMEOUT_CYC(20), .MS_CYC(4)) DUT (.pclk(pclk),
      .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cond(cond),
      .fault_out_n(fault_out_n), .fets_float(fets_float),
      .pump_en(pump_en), .logic_reset(logic_reset), .irq(irq));
   fmr_host host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic chk(input string nm, input logic [31:0] x,
         input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic bit1(input string nm, input logic x, input logic g);
      chk(nm, {31'h0, x}, {31'h0, g});
   endtask

   task automatic pins(input logic pn, input logic fl);
      bit1("fault_out_n", pn, fault_out_n);
      bit1("fets_float", fl, fets_float);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
         input logic [31:0] m, input logic [31:0] x);
      host.rd(a, q, e);
      chk(nm, x, q & m);
   endtask

   task automatic t_reset();
      pins(1'b1, 1'b0);
      bit1("pump_en", 1'b1, pump_en);
      rdchk("cfg", CFG, 32'hFFFF_FFFF, fmr_pkg::CFG_RST);
      rdchk("irq_mask", fmr_pkg::ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
      host.rd(8'h14, q, e);
      bit1("pslverr", 1'b1, e);
   endtask

   // Kind 0 and 1 are ramp timeouts, kind 2 a pulse before decay.
   task automatic t_retry(input int k, input logic en);
      logic [31:0] v;
      v = fmr_pkg::CFG_RST;
      v[k == 2] = en;
      host.wr(CFG, v);
      if (k == 2) begin
         cond.probe_pulse_start <= 1'b1;
         cyc(1);
         cond.probe_pulse_start <= 1'b0;
      end else begin
         cond.probe_rampup <= (k == 0);
         cond.probe_rampdn <= (k == 1);
         cyc(24);
         cond.probe_rampup <= 1'b0;
         cond.probe_rampdn <= 1'b0;
      end
      cyc(3);
      pins(!en, en);
      cyc(30);
      pins(!en, en);
      cyc(15);
      pins(1'b1, 1'b0);
      rdchk("probe_flags", FLT, 32'h0000_0007, 32'h0);
   endtask

   task automatic t_latch(input int k);
      if (k == 0) begin
         cond.meas_rl <= 1'b1;
         cond.probe_rampup <= 1'b1;
         cyc(24);
         cond.probe_rampup <= 1'b0;
      end else begin
         cond.meas_ke <= 1'b1;
         cond.backemf_low <= 1'b1;
      end
      cyc(50);
      pins(1'b0, 1'b1);
      if (k == 1) begin
         host.clear_faults();
         pins(1'b0, 1'b1);
      end
      cond.meas_rl <= 1'b0;
      cond.meas_ke <= 1'b0;
      cond.backemf_low <= 1'b0;
      cyc(1);
      host.clear_faults();
      cyc(3);
      pins(1'b1, 1'b0);
   endtask

   // Sources: 0 watchdog, 1 memory read error, 2 checksum error.
   task automatic t_mode(input int f, input logic m);
      logic [31:0] v;
      v = fmr_pkg::CFG_RST;
      v[f + 3] = m;
      if (f == 0) begin
         v[31:16] = 16'h0002;
         v[2] = 1'b1;
      end
      host.wr(CFG, v);
      if (f == 0) begin
         cyc(14);
      end else begin
         cond.mem_rd_done <= (f == 1);
         cond.crc_err <= (f == 2);
         cyc(1);
         cond.mem_rd_done <= 1'b0;
         cond.crc_err <= 1'b0;
      end
      cyc(3);
      pins(1'b0, (f == 0) == m);
      host.wr(CFG, fmr_pkg::CFG_RST);
      host.clear_faults();
      cyc(3);
      pins(1'b1, 1'b0);
   endtask

   task automatic t_tickle();
      host.wr(CFG, 32'h0002_0A0C);
      repeat (6) host.tickle();
      pins(1'b1, 1'b0);
      cyc(14);
      pins(1'b0, 1'b1);
      host.wr(CFG, fmr_pkg::CFG_RST);
      host.clear_faults();
      cyc(3);
      pins(1'b1, 1'b0);
   endtask

   task automatic t_sat(input int s);
      host.wr(CFG, 32'h0064_0A40);
      cond.cur_sat <= (s == 0);
      cond.spd_sat <= (s == 1);
      cyc(3);
      pins(1'b0, 1'b0);
      rdchk("sat", FLT, 32'h0000_0300, 32'h0000_0100 << s);
      cond.cur_sat <= 1'b0;
      cond.spd_sat <= 1'b0;
      cyc(3);
      pins(1'b1, 1'b0);
   endtask

   task automatic t_pump();
      host.wr(fmr_pkg::ADDR_IRQ_MASK, 32'h0000_0400);
      cond.pump_uv <= 1'b1;
      cyc(2);
      pins(1'b0, 1'b1);
      bit1("irq", 1'b1, irq);
      cond.pump_uv <= 1'b0;
      cyc(2);
      pins(1'b1, 1'b0);
      rdchk("pump", FLT, 32'h0000_2400, 32'h0000_2400);
      rdchk("irq_stat", fmr_pkg::ADDR_IRQ_STAT, 32'h400, 32'h400);
      bit1("irq", 1'b0, irq);
      host.clear_faults();
      rdchk("pump", FLT, 32'h0000_2400, 32'h0);
   endtask

   task automatic t_buck();
      cond.buck_uv <= 1'b1;
      cyc(3);
      pins(1'b1, 1'b0);
      bit1("pump_en", 1'b1, pump_en);
      rdchk("buck", FLT, 32'h0000_0800, 32'h0000_0800);
      bit1("irq", 1'b0, irq);
      cond.buck_uv <= 1'b0;
   endtask

   task automatic t_supply(input int s);
      host.wr(CFG, 32'h0064_0A41);
      cond.main_uv <= (s == 0);
      cond.analog_uv <= (s == 1);
      cyc(3);
      bit1("logic_reset", 1'b1, logic_reset);
      bit1("pump_en", 1'b0, pump_en);
      bit1("fets_float", 1'b1, fets_float);
      cond.main_uv <= 1'b0;
      cond.analog_uv <= 1'b0;
      cyc(3);
      bit1("logic_reset", 1'b0, logic_reset);
      rdchk("cfg", CFG, 32'hFFFF_FFFF, fmr_pkg::CFG_RST);
   endtask

   // Clock enable low must hold every registered output and flag where it was.
   task automatic t_freeze();
      ce <= 1'b0;
      cond.pump_uv <= 1'b1;
      cyc(3);
      pins(1'b1, 1'b0);
      bit1("pready", 1'b0, pready);
      ce <= 1'b1;
      cyc(2);
      pins(1'b0, 1'b1);
      cond.pump_uv <= 1'b0;
      cyc(2);
      pins(1'b1, 1'b0);
      rdchk("pump", FLT, 32'h0000_2400, 32'h0000_2400);
   endtask

   task automatic summarize();
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      cyc(6);
      presetn <= 1'b1;
      cyc(2);
      t_reset();
      for (int k = 0; k < 3; k++) begin
         t_retry(k, 1'b0);
         t_retry(k, 1'b1);
      end
      t_latch(0);
      t_latch(1);
      for (int f = 0; f < 3; f++) begin
         t_mode(f, 1'b0);
         t_mode(f, 1'b1);
      end
      t_tickle();
      t_sat(0);
      t_sat(1);
      t_pump();
      t_buck();
      t_supply(0);
      t_supply(1);
      t_freeze();
      summarize();
   end

   // The whole sequence needs under 2000 cycles; this allows ten times that.
   initial begin
      cyc(20000);
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
